// ==== common/self_program_flash_control_consts.vh ====
// constants for the self-programming flash controller
// assumes inclusion by bare name from design files
`ifndef SELF_PROGRAM_FLASH_CONTROL_CONSTS_VH
`define SELF_PROGRAM_FLASH_CONTROL_CONSTS_VH
// register byte addresses
`define ADDR_CTRL_STATUS   8'h68
`define ADDR_LOCK_BYTE     8'h6c
`define ADDR_FUSE_LOW      8'h70
`define ADDR_FUSE_HIGH     8'h74
`define ADDR_FUSE_EXT      8'h78
`define ADDR_OP_STATUS     8'h7c
// control/status field positions
`define BIT_IRQ_ENABLE     7
`define BIT_REGION_BUSY    6
`define BIT_REENABLE       4
`define BIT_LOCK_SET       3
`define BIT_PAGE_PROGRAM   2
`define BIT_PAGE_CLEAR     1
`define BIT_STORE_ENABLE   0
// valid low-five patterns
`define PAT_STORE_ONLY     5'h01
`define PAT_REENABLE       5'h11
`define PAT_LOCK_SET       5'h09
`define PAT_PAGE_PROGRAM   5'h05
`define PAT_PAGE_CLEAR     5'h03
// reset and default values
`define RST_CTRL_STATUS    8'h00
`define DEF_LOCK_BYTE      8'hff
`define DEF_FUSE_LOW       8'he1
`define DEF_FUSE_HIGH      8'h99
`define DEF_FUSE_EXT       8'hfd
// lock byte field positions
`define BIT_MEMORY_LOCK_1  0
`define BIT_MEMORY_LOCK_2  1
`define BIT_APP_LOCK_1     2
`define BIT_APP_LOCK_2     3
`define BIT_BOOT_LOCK_1    4
`define BIT_BOOT_LOCK_2    5
// region layout in pages
`define LIVE_REGION_PAGES  224
`define STALL_REGION_PAGES 32
// timing
`define STORE_WINDOW_CYC   4
`define LOAD_WINDOW_CYC    3
`define PROG_TIME_MIN_NS   3700000
`define CLK_PERIOD_NS      10
`define PROG_CYCLES        ((`PROG_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== design/self_program_flash_control.v ====
// self-programming flash controller: control/status register, page buffer,
// erase/program/lock sequencing, region busy and lock checks, fuse readback
// assumes a classic wishbone master on clk_i and a cpu that issues store/load strobes on clk_i
// Functional notes
// - flash splits into 224 low live pages and 32 high stalling pages.
// - ready interrupt is high while irq enable, global enable set, store enable clear.
// - region busy sets on erase/program of live region; live region then unreadable.
// - region busy clears on reenable after completion or on buffer load start.
// - reenable with store enable, store within four cycles; refused while busy.
// - writing reenable during buffer loading aborts load and discards data.
// - lock set with store: program boot locks from r0; bit self-clears.
// - load within three cycles after lock set returns lock or a fuse byte by pointer bits 1:0.
// - page program with store programs buffer into addressed page; self-clears.
// - cpu halts during erase or program of a stalling-region page.
// - page clear with store erases addressed page; self-clears.
// - store enable alone: store writes r1:r0 into buffer, pointer lsb ignored.
// - store enable opens four-cycle window, clears on store or timeout, held during op.
// - only five low-bit patterns take effect; others ignored.
// - lock byte: memory locks 1:0, boot locks 5:2, bits 7:6 read one.
// - memory lock 1 blocks external programming; both block verification too.
// - app lock 1 programmed rejects stores into application region.
// - app lock 2 blocks boot-side loads of app region and app-side interrupts.
// - boot lock 1 programmed rejects stores into boot region.
// - boot lock 2 blocks app-side loads of boot region and boot-side interrupts.
// - three fuse bytes; extended byte compat bit 1, watchdog bit 0, top ones.
// - configuration reads return unprogrammed bits one, programmed zero.
`timescale 1ns/100ps
`include "self_program_flash_control_consts.vh"
module self_program_flash_control #(
    parameter PAGE_WORDS  = 128,
    parameter PAGE_BITS   = 8,
    parameter PROG_CYCLES = `PROG_CYCLES,
    parameter BOOT_PAGES  = 32
) (
    // clock, reset, enable
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // cpu store/load strobes and operands
    input  wire        store_i,
    input  wire        load_i,
    input  wire [15:0] pointer_i,
    input  wire [15:0] data_i,
    input  wire        exec_in_boot_i,
    input  wire        vectors_in_boot_i,
    input  wire        global_irq_en_i,
    output reg  [7:0]  load_data_o,
    output reg         load_valid_o,
    // flash array side
    output reg         flash_erase_o,
    output reg         flash_write_o,
    output reg  [7:0]  flash_page_o,
    output reg         live_region_readable_o,
    output reg         cpu_halt_o,
    output reg         irq_o,
    output reg         irq_block_o,
    output reg         ext_prog_block_o,
    output reg         ext_verify_block_o,
    output reg         boot_read_block_o,
    output reg         app_read_block_o
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_OPEN = 2'h1;
    localparam [1:0] ST_BUSY = 2'h2;
    localparam integer WIN_STORE_N = `STORE_WINDOW_CYC;
    localparam integer WIN_LOAD_N  = `LOAD_WINDOW_CYC;
    localparam integer LIVE_N      = `LIVE_REGION_PAGES;
    localparam [2:0] WIN_STORE = WIN_STORE_N[2:0];
    localparam [2:0] WIN_LOAD  = WIN_LOAD_N[2:0];
    localparam [31:0] PROG_LEN = PROG_CYCLES;
    localparam [7:0] BOOT_START = 8'hff - BOOT_PAGES[7:0] + 8'h01;
    localparam [7:0] LIVE_PAGES = LIVE_N[7:0];

    reg [15:0] page_buf [0:PAGE_WORDS-1];
    reg [PAGE_WORDS-1:0] buf_valid_q;
    reg [1:0]  state_q;
    reg [4:0]  op_q;
    reg [2:0]  win_q;
    reg [31:0] prog_cnt_q;
    reg        irq_en_q;
    reg        busy_q;
    reg        loading_q;
    reg        last_refused_q;
    reg [7:0]  lock_q;
    reg [7:0]  fuse_low_q;
    reg [7:0]  fuse_high_q;
    reg [7:0]  fuse_ext_q;
    reg [31:0] rd_d;

    wire       bus_req    = cyc_i & stb_i & ~ack_o;
    wire       ctrl_wr    = bus_req & we_i & sel_i[0] & (adr_i == `ADDR_CTRL_STATUS);
    wire [4:0] wr_pat     = dat_i[4:0];
    wire       pat_ok     = (wr_pat == `PAT_STORE_ONLY) | (wr_pat == `PAT_REENABLE) |
                            (wr_pat == `PAT_LOCK_SET) | (wr_pat == `PAT_PAGE_PROGRAM) |
                            (wr_pat == `PAT_PAGE_CLEAR);
    wire [7:0] tgt_page   = pointer_i[15:8];
    wire       tgt_boot   = (tgt_page >= BOOT_START);
    wire       tgt_live   = (tgt_page < LIVE_PAGES);
    wire       app_wr_blk = ~lock_q[`BIT_APP_LOCK_1] & ~tgt_boot;
    wire       boot_wr_blk = ~lock_q[`BIT_BOOT_LOCK_1] & tgt_boot;
    wire       wr_blocked = app_wr_blk | boot_wr_blk;
    wire       win_store  = (state_q == ST_OPEN) & store_i;
    wire [6:0] word_idx   = pointer_i[7:1];
    wire       op_erase   = (op_q == `PAT_PAGE_CLEAR);
    wire       op_prog    = (op_q == `PAT_PAGE_PROGRAM);
    wire       ctrl_open  = (state_q != ST_IDLE);

    always @* begin
        rd_d = 32'h0;
        case (adr_i)
            `ADDR_CTRL_STATUS: rd_d = {24'h0, irq_en_q, busy_q, 1'b0, op_q[4:1], ctrl_open};
            `ADDR_LOCK_BYTE:   rd_d = {24'h0, lock_q};
            `ADDR_FUSE_LOW:    rd_d = {24'h0, fuse_low_q};
            `ADDR_FUSE_HIGH:   rd_d = {24'h0, fuse_high_q};
            `ADDR_FUSE_EXT:    rd_d = {24'h0, fuse_ext_q};
            `ADDR_OP_STATUS:   rd_d = {29'h0, last_refused_q, loading_q, state_q == ST_BUSY};
            default:           rd_d = 32'h0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o        <= 1'b0;
            dat_o        <= 32'h0;
            state_q      <= ST_IDLE;
            op_q         <= 5'h0;
            win_q        <= 3'h0;
            prog_cnt_q   <= 32'h0;
            irq_en_q     <= 1'b0;
            busy_q       <= 1'b0;
            loading_q    <= 1'b0;
            last_refused_q <= 1'b0;
            buf_valid_q  <= {PAGE_WORDS{1'b0}};
            lock_q       <= `DEF_LOCK_BYTE;
            fuse_low_q   <= `DEF_FUSE_LOW;
            fuse_high_q  <= `DEF_FUSE_HIGH;
            fuse_ext_q   <= `DEF_FUSE_EXT;
            load_data_o  <= 8'h0;
            load_valid_o <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_write_o <= 1'b0;
            flash_page_o <= 8'h0;
            live_region_readable_o <= 1'b1;
            cpu_halt_o   <= 1'b0;
            irq_o        <= 1'b0;
            irq_block_o  <= 1'b0;
            ext_prog_block_o   <= 1'b0;
            ext_verify_block_o <= 1'b0;
            boot_read_block_o  <= 1'b0;
            app_read_block_o   <= 1'b0;
        end else if (ce_i) begin
            ack_o         <= bus_req;
            dat_o         <= bus_req ? rd_d : 32'h0;
            load_valid_o  <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_write_o <= 1'b0;
            if (ctrl_wr) begin
                irq_en_q <= dat_i[`BIT_IRQ_ENABLE];
            end
            case (state_q)
                ST_IDLE: begin
                    if (ctrl_wr && pat_ok) begin
                        state_q <= ST_OPEN;
                        op_q    <= wr_pat;
                        win_q   <= WIN_STORE;
                        if (wr_pat == `PAT_REENABLE && loading_q) begin
                            buf_valid_q <= {PAGE_WORDS{1'b0}};
                            loading_q   <= 1'b0;
                        end
                    end
                end
                ST_OPEN: begin
                    if (load_i && op_q == `PAT_LOCK_SET && win_q > (WIN_STORE - WIN_LOAD)) begin
                        load_data_o  <= pointer_i[0] ? fuse_low_q : lock_q;
                        if (pointer_i[1:0] == 2'h3) begin
                            load_data_o <= fuse_high_q;
                        end else if (pointer_i[1:0] == 2'h2) begin
                            load_data_o <= fuse_ext_q;
                        end
                        load_valid_o <= 1'b1;
                    end
                    if (win_store) begin
                        last_refused_q <= 1'b0;
                        state_q <= ST_IDLE;
                        op_q    <= 5'h0;
                        case (op_q)
                            `PAT_STORE_ONLY: begin
                                page_buf[word_idx]    <= data_i;
                                buf_valid_q[word_idx] <= 1'b1;
                                loading_q <= 1'b1;
                                busy_q    <= 1'b0;
                            end
                            `PAT_REENABLE: begin
                                busy_q <= 1'b0;
                            end
                            `PAT_LOCK_SET: begin
                                // lock bits only go toward programmed; reset restores them
                                lock_q <= lock_q & {2'b11, data_i[5:2], 2'b11};
                            end
                            default: begin
                                if (wr_blocked) begin
                                    last_refused_q <= 1'b1;
                                end else begin
                                    state_q      <= ST_BUSY;
                                    op_q         <= op_q;
                                    prog_cnt_q   <= PROG_LEN;
                                    flash_page_o <= tgt_page;
                                    flash_erase_o <= op_erase;
                                    flash_write_o <= op_prog;
                                    if (tgt_live) begin
                                        busy_q <= 1'b1;
                                    end else begin
                                        cpu_halt_o <= 1'b1;
                                    end
                                end
                            end
                        endcase
                    end else if (win_q == 3'h1) begin
                        state_q <= ST_IDLE;
                        op_q    <= 5'h0;
                    end else begin
                        win_q <= win_q - 3'h1;
                    end
                end
                ST_BUSY: begin
                    if (prog_cnt_q <= 32'h1) begin
                        state_q    <= ST_IDLE;
                        op_q       <= 5'h0;
                        cpu_halt_o <= 1'b0;
                        if (op_prog) begin
                            buf_valid_q <= {PAGE_WORDS{1'b0}};
                            loading_q   <= 1'b0;
                        end
                    end else begin
                        prog_cnt_q <= prog_cnt_q - 32'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            live_region_readable_o <= ~busy_q;
            irq_o <= irq_en_q & global_irq_en_i & ~ctrl_open;
            ext_prog_block_o   <= ~lock_q[`BIT_MEMORY_LOCK_1];
            ext_verify_block_o <= ~lock_q[`BIT_MEMORY_LOCK_1] & ~lock_q[`BIT_MEMORY_LOCK_2];
            app_read_block_o   <= ~lock_q[`BIT_APP_LOCK_2] & exec_in_boot_i;
            boot_read_block_o  <= ~lock_q[`BIT_BOOT_LOCK_2] & ~exec_in_boot_i;
            irq_block_o <= (~lock_q[`BIT_APP_LOCK_2] & vectors_in_boot_i & ~exec_in_boot_i) |
                           (~lock_q[`BIT_BOOT_LOCK_2] & ~vectors_in_boot_i & exec_in_boot_i);
        end
    end
endmodule // self_program_flash_control

// ==== dv/cpu_store_model.sv ====
// cpu core model issuing store and load strobes with operands
// assumes the caller enters issue right after a rising edge
`timescale 1ns/100ps
module cpu_store_model (
    // clock
    input  wire        clk_i,
    // strobes and operands towards the controller
    output reg         store_o,
    output reg         load_o,
    output reg  [15:0] pointer_o,
    output reg  [15:0] data_o
);
    initial begin
        store_o = 1'b0;
        load_o = 1'b0;
        pointer_o = 16'h0;
        data_o = 16'h0;
    end
    // one strobe cycle; operands scrambled once sampled so stale values never pass
    task issue(input st, input [15:0] p, input [15:0] d);
        store_o <= st;
        load_o <= !st;
        pointer_o <= p;
        data_o <= d;
        @(posedge clk_i);
        store_o <= 1'b0;
        load_o <= 1'b0;
        pointer_o <= ~p;
        data_o <= ~d;
    endtask
endmodule // cpu_store_model

// ==== dv/self_program_flash_control_assertions.sv ====
// port checker for the self-programming flash controller
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module flash_ctrl_checker #(parameter PROG_CYCLES = 20) (
    input wire        clk_i, rst_i, store_i, load_i, global_irq_en_i,
    input wire [15:0] pointer_i,
    input wire        load_valid_o, flash_erase_o, flash_write_o, cpu_halt_o, irq_o,
    input wire        live_region_readable_o, ext_prog_block_o, ext_verify_block_o,
    input wire [7:0]  flash_page_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire       op_start = flash_erase_o | flash_write_o;
    wire [7:0] ptr_page = pointer_i[15:8];
    reg [31:0] halt_q;
    // length of the current halt in cycles, wide enough for the full programming time
    always @(posedge clk_i) halt_q <= (cpu_halt_o && !rst_i) ? halt_q + 32'h1 : 32'h0;
    a_irq_gated: assert property (!global_irq_en_i && $past(global_irq_en_i) == 1'b0 |-> !irq_o)
        else $error("irq high without global enable");
    a_irq_quiet_op: assert property (op_start |-> !irq_o)
        else $error("irq high while an operation starts");
    a_busy_live: assert property (op_start && flash_page_o < 8'd224 |-> ##[0:2] !live_region_readable_o)
        else $error("live region readable during its own operation");
    a_stall_halt: assert property (op_start && flash_page_o >= 8'd224 |-> ##[0:2] cpu_halt_o)
        else $error("no halt for stalling region operation");
    a_halt_span: assert property ($fell(cpu_halt_o) |-> halt_q + 2 >= PROG_CYCLES && halt_q <= PROG_CYCLES + 2)
        else $error("halt length differs from programming time");
    a_load_cause: assert property (load_valid_o |-> $past(load_i))
        else $error("load data without a load strobe");
    a_write_cause: assert property (flash_write_o |-> $past(store_i))
        else $error("page program without a store");
    a_erase_cause: assert property (flash_erase_o |-> $past(store_i))
        else $error("page clear without a store");
    a_page_select: assert property (op_start |-> flash_page_o == $past(ptr_page))
        else $error("page differs from pointer high byte");
    a_verify_lock: assert property (ext_verify_block_o |-> ext_prog_block_o)
        else $error("verify blocked without program block");
endmodule // flash_ctrl_checker
bind self_program_flash_control flash_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .clk_i(clk_i), .rst_i(rst_i), .store_i(store_i), .load_i(load_i), .global_irq_en_i(global_irq_en_i),
    .pointer_i(pointer_i), .load_valid_o(load_valid_o), .flash_erase_o(flash_erase_o),
    .flash_write_o(flash_write_o), .cpu_halt_o(cpu_halt_o), .irq_o(irq_o),
    .live_region_readable_o(live_region_readable_o), .ext_prog_block_o(ext_prog_block_o),
    .ext_verify_block_o(ext_verify_block_o), .flash_page_o(flash_page_o));

// ==== dv/self_program_flash_control_test.sv ====
// testbench for the self-programming flash controller
// assumes the design ports and a short programming time
`timescale 1ns/100ps
module self_program_flash_control_test;
    localparam PROG = 20;
    localparam [31:0] DFLT = 32'hfd99e1ff;
    reg         clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    reg         exec_in_boot_i = 1, vectors_in_boot_i = 0, global_irq_en_i = 0;
    reg  [7:0]  adr_i = 0;
    reg  [3:0]  sel_i = 0;
    reg  [4:0]  v;
    reg  [31:0] dat_i = 0, seed = 32'hb86a316b, m;
    wire [31:0] dat_o;
    wire [15:0] pointer_i, data_i;
    wire [7:0]  load_data_o, flash_page_o;
    wire        ack_o, store_i, load_i, load_valid_o, flash_erase_o, flash_write_o, cpu_halt_o, irq_o;
    wire        live_region_readable_o, irq_block_o, ext_prog_block_o, ext_verify_block_o;
    wire        boot_read_block_o, app_read_block_o;
    reg  [31:0] exp_q[$], msk_q[$];
    integer     n_fail = 0, tests_run = 0, n_ops = 0, cycles = 0, i;
    always #5 clk_i = ~clk_i;
    cpu_store_model cpu (.clk_i(clk_i), .store_o(store_i), .load_o(load_i), .pointer_o(pointer_i), .data_o(data_i));
    self_program_flash_control #(.PROG_CYCLES(PROG)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .store_i(store_i), .load_i(load_i), .pointer_i(pointer_i), .data_i(data_i),
        .exec_in_boot_i(exec_in_boot_i), .vectors_in_boot_i(vectors_in_boot_i),
        .global_irq_en_i(global_irq_en_i), .load_data_o(load_data_o), .load_valid_o(load_valid_o),
        .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o), .flash_page_o(flash_page_o),
        .live_region_readable_o(live_region_readable_o), .cpu_halt_o(cpu_halt_o), .irq_o(irq_o),
        .irq_block_o(irq_block_o), .ext_prog_block_o(ext_prog_block_o),
        .ext_verify_block_o(ext_verify_block_o), .boot_read_block_o(boot_read_block_o),
        .app_read_block_o(app_read_block_o));
    function [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wb(input w, input [7:0] a, input [31:0] d, input [31:0] mk);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
        if (!w) begin
            exp_q.push_back(d);
            msk_q.push_back(mk);
        end
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    task op(input [7:0] c, input s, input [15:0] p, input [15:0] d);
        wb(1, 8'h68, {24'h0, c | 8'h80}, 0);
        cpu.issue(s, p, d);
    endtask
    // read results and load data are compared against the oldest note; flash pulses are counted
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if ((ack_o && !we_i) || load_valid_o) begin
            m = msk_q.pop_front();
            check((ack_o ? dat_o : {24'h0, load_data_o}) & m, exp_q.pop_front());
        end
        n_ops = n_ops + (flash_erase_o | flash_write_o);
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            conclude;
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 8'h68, 0, 32'hff);
        wb(0, 8'h40, 0, 32'hffffffff);
        wb(1, 8'h6c, 0, 0);
        for (i = 0; i < 4; i = i + 1) wb(0, 8'h6c + 4 * i, DFLT[8*i +: 8], 32'hff);
        wb(1, 8'h68, 32'h80, 0);
        global_irq_en_i <= 1;
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 1);
        for (i = 0; i < 4; i = i + 1) begin
            exp_q.push_back(DFLT[8*i +: 8]);
            msk_q.push_back(32'hff);
            op(8'h09, 0, {14'h0, i[1], i[1] ^ i[0]}, 0);
            repeat (6) @(posedge clk_i);
        end
        wb(0, 8'h68, 0, 32'h1f);
        for (i = 0; i < 3; i = i + 1) begin
            seed = xs(seed);
            v = seed[4:0] | 5'h06;
            op({3'h0, v}, 1, {seed[15:8], 8'h0}, seed[31:16]);
            repeat (6) @(posedge clk_i);
            wb(0, 8'h68, 0, 32'h1f);
        end
        global_irq_en_i <= 0;
        op(8'h03, 1, 16'h0500, 0);
        global_irq_en_i <= 1;
        wb(0, 8'h68, 32'h41, 32'h41);
        op(8'h11, 1, 0, 0);
        repeat (PROG + 4) @(posedge clk_i);
        wb(0, 8'h68, 32'h40, 32'h41);
        op(8'h11, 1, 0, 0);
        repeat (4) @(posedge clk_i);
        wb(0, 8'h68, 0, 32'h51);
        op(8'h05, 1, 16'hf000, 0);
        repeat (PROG + 4) @(posedge clk_i);
        wb(0, 8'h68, 0, 32'h47);
        op(8'h03, 1, 16'h0600, 0);
        repeat (PROG + 4) @(posedge clk_i);
        seed = xs(seed);
        op(8'h01, 1, {8'h06, seed[7:1], 1'b1}, seed[31:16]);
        repeat (4) @(posedge clk_i);
        wb(0, 8'h68, 0, 32'h41);
        wb(0, 8'h7c, 32'h2, 32'h2);
        op(8'h11, 1, 0, 0);
        wb(0, 8'h7c, 0, 32'h2);
        op(8'h09, 1, 16'hffff, 16'hfff3);
        repeat (PROG + 4) @(posedge clk_i);
        wb(0, 8'h6c, 32'hf3, 32'hff);
        check({31'h0, app_read_block_o}, 1);
        exec_in_boot_i <= 0;
        vectors_in_boot_i <= 1;
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_block_o}, 1);
        check({30'h0, app_read_block_o, boot_read_block_o}, 0);
        check({30'h0, ext_prog_block_o, ext_verify_block_o}, 0);
        op(8'h03, 1, 16'h0500, 0);
        repeat (PROG + 4) @(posedge clk_i);
        wb(0, 8'h7c, 1, 32'h01);
        check(n_ops, 3);
        conclude;
    end
endmodule // self_program_flash_control_test
